// File: rtl/qpd_pkg.sv
// constants and types for the quad pot transfer command decoder
// Notes on behaviour
// (R1) instruction 0001 ss 00 loads slot ss of all four pots into their wipers.
// (R2) instruction 1000 ss 00 saves every wiper into slot ss of its own pot.
// (R3) instruction 1110 ss pp saves wiper pp into slot ss of pot pp.
// (R4) instruction 1101 ss pp loads slot ss of pot pp into its wiper.
// (R5) instruction 0010 00 pp is acknowledged, then direction bits follow unacknowledged until stop.
// (R6) nonvolatile programming starts only after the stop that ends a saving frame.
// (R7) each stepping clock pulse moves the wiper up one tap if data is high, down if low.
// (R8) the master waits the programming time before relying on a save.
// (R9) the slave address is not acknowledged while programming is in progress.
package qpd_pkg;
  localparam logic [3:0] QPD_DEV_TYPE   = 4'h5;  // fixed upper address nibble 0101
  localparam logic [3:0] QPD_OP_GLOAD   = 4'h1;
  localparam logic [3:0] QPD_OP_GSAVE   = 4'h8;
  localparam logic [3:0] QPD_OP_SAVE    = 4'he;
  localparam logic [3:0] QPD_OP_LOAD    = 4'hd;
  localparam logic [3:0] QPD_OP_STEP    = 4'h2;
  localparam logic [5:0] QPD_WIPER_RST  = 6'h00;
  localparam logic [5:0] QPD_WIPER_MAX  = 6'h3f;
  localparam int         QPD_CLK_MHZ    = 50;
  localparam int         QPD_TWR_US     = 5;     // programming time
  localparam int         QPD_TWR_CYC    = QPD_TWR_US * QPD_CLK_MHZ;
  typedef enum logic [4:0] {
    QPD_ST_IDLE = 5'b00001,
    QPD_ST_ADDR = 5'b00010,
    QPD_ST_INST = 5'b00100,
    QPD_ST_STEP = 5'b01000,
    QPD_ST_SKIP = 5'b10000
  } qpd_state_t;
endpackage

// File: rtl/qpd_decoder.sv
// i2c instruction decoder for four wipers with four stored slots each
module qpd_decoder #(
  parameter int PROG_CYC = qpd_pkg::QPD_TWR_CYC
) (
  // clock, reset, enable
  input  wire  logic        mclk,
  input  wire  logic        rst,
  input  wire  logic        clk_en,
  // i2c pins
  input  wire  logic        scl_in,
  input  wire  logic        sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  // address straps
  input  wire  logic [3:0]  address_strap,
  // wiper positions, pot 0 in the low bits
  output logic [23:0]       wiper_position_register,
  // stored settings, index pot*4+slot
  output logic [95:0]       stored_setting_register,
  // status
  output logic              prog_busy
);
  // programming counter is 16 bits wide, so refuse longer times at elaboration
  if (PROG_CYC < 1 || PROG_CYC > 65535) begin : g_prog_chk
    $error("PROG_CYC out of range");
  end

  // pin synchronisers
  logic [1:0] scl_s_q, sda_s_q;
  logic       scl_p_q, sda_p_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else if (clk_en) begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  wire scl = scl_s_q[1];
  wire sda = sda_s_q[1];
  wire scl_rise = scl & ~scl_p_q;
  wire scl_fall = ~scl & scl_p_q;
  wire start_ev = scl & scl_p_q & sda_p_q & ~sda;
  wire stop_ev  = scl & scl_p_q & ~sda_p_q & sda;

  qpd_pkg::qpd_state_t st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;     // bit count within byte, 8 means all eight bits are in
  logic [7:0]  sh_q, sh_d;
  logic        ack_q, ack_d;     // driving ack low this ninth bit
  logic [1:0]  pot_q, pot_d;
  logic        pend_q, pend_d;   // save done, awaiting stop
  logic [15:0] pcnt_q, pcnt_d;
  logic [23:0] wpr_d;
  logic [95:0] ssr_d;
  logic        sda_out_d, sda_oe_d, busy_d;
  logic [7:0]  ins;

  // frame decode, wiper and slot updates
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; ack_d = ack_q; pot_d = pot_q;
    pend_d = pend_q; pcnt_d = pcnt_q; busy_d = prog_busy;
    wpr_d = wiper_position_register; ssr_d = stored_setting_register;
    ins = {sh_q[6:0], sda};
    if (pcnt_q != 16'h0000) pcnt_d = pcnt_q - 16'h0001;
    if (pcnt_q == 16'h0001) busy_d = 1'b0;
    if (start_ev) begin
      st_d = qpd_pkg::QPD_ST_ADDR; cnt_d = 4'h0; ack_d = 1'b0;
    end else if (stop_ev) begin
      st_d = qpd_pkg::QPD_ST_IDLE; ack_d = 1'b0;
      // (R6) programming after stop
      if (pend_q) begin
        pend_d = 1'b0; busy_d = 1'b1; pcnt_d = 16'(PROG_CYC);
      end
    end else if (scl_rise) begin
      case (st_q)
        qpd_pkg::QPD_ST_ADDR, qpd_pkg::QPD_ST_INST: begin
          if (cnt_q < 4'h8) begin
            sh_d = ins; cnt_d = cnt_q + 4'h1;
          end
        end
        // direction sampled on the rise, applied on the fall
        qpd_pkg::QPD_ST_STEP: sh_d = ins;
        default: ;
      endcase
    end else if (scl_fall) begin
      if (ack_q) begin
        ack_d = 1'b0; cnt_d = 4'h0;
      end else if (st_q == qpd_pkg::QPD_ST_STEP) begin
        // (R7) one tap per completed pulse
        // a pulse counts only when it falls: the rise before a stop never
        // completes, and the ack slot is skipped by the branch above
        if (sh_q[0] && wpr_d[pot_q*6 +: 6] != qpd_pkg::QPD_WIPER_MAX)
          wpr_d[pot_q*6 +: 6] = wpr_d[pot_q*6 +: 6] + 6'h01;
        else if (!sh_q[0] && wpr_d[pot_q*6 +: 6] != qpd_pkg::QPD_WIPER_RST)
          wpr_d[pot_q*6 +: 6] = wpr_d[pot_q*6 +: 6] - 6'h01;
      end else if (cnt_q == 4'h8) begin
        cnt_d = 4'h0;
        case (st_q)
          qpd_pkg::QPD_ST_ADDR: begin
            // (R9) no ack while busy
            if (sh_q[7:4] == qpd_pkg::QPD_DEV_TYPE && sh_q[3:0] == address_strap
                && !prog_busy) begin
              ack_d = 1'b1; st_d = qpd_pkg::QPD_ST_INST;
            end else st_d = qpd_pkg::QPD_ST_SKIP;
          end
          qpd_pkg::QPD_ST_INST: begin
            ack_d = 1'b1; st_d = qpd_pkg::QPD_ST_SKIP; pot_d = sh_q[1:0];
            case (sh_q[7:4])
              // (R1) gang load
              qpd_pkg::QPD_OP_GLOAD: begin
                for (int p = 0; p < 4; p++)
                  wpr_d[p*6 +: 6] = ssr_d[(p*4 + sh_q[3:2])*6 +: 6];
              end
              // (R2) gang save
              qpd_pkg::QPD_OP_GSAVE: begin
                for (int p = 0; p < 4; p++)
                  ssr_d[(p*4 + sh_q[3:2])*6 +: 6] = wpr_d[p*6 +: 6];
                pend_d = 1'b1;
              end
              // (R3) single save
              qpd_pkg::QPD_OP_SAVE: begin
                ssr_d[(sh_q[1:0]*4 + sh_q[3:2])*6 +: 6] = wpr_d[sh_q[1:0]*6 +: 6];
                pend_d = 1'b1;
              end
              // (R4) single load
              qpd_pkg::QPD_OP_LOAD:
                wpr_d[sh_q[1:0]*6 +: 6] = ssr_d[(sh_q[1:0]*4 + sh_q[3:2])*6 +: 6];
              // (R5) stepping, bits then unacknowledged
              qpd_pkg::QPD_OP_STEP: st_d = qpd_pkg::QPD_ST_STEP;
              default: ack_d = 1'b0;
            endcase
          end
          default: ;
        endcase
      end
    end
    sda_out_d = 1'b0;
    sda_oe_d  = ack_d;
  end

  // state registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= qpd_pkg::QPD_ST_IDLE;
      cnt_q <= 4'h0; sh_q <= 8'h00; ack_q <= 1'b0; pot_q <= 2'h0;
      pend_q <= 1'b0; pcnt_q <= 16'h0000; prog_busy <= 1'b0;
      sda_out <= 1'b0; sda_oe <= 1'b0;
      wiper_position_register <= '0;
      stored_setting_register <= '0;
    end else if (clk_en) begin
      st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; ack_q <= ack_d; pot_q <= pot_d;
      pend_q <= pend_d; pcnt_q <= pcnt_d; prog_busy <= busy_d;
      sda_out <= sda_out_d; sda_oe <= sda_oe_d;
      wiper_position_register <= wpr_d;
      stored_setting_register <= ssr_d;
    end
  end

  // checks

  // (R6) programming only after stop
  a_prog_after_stop: assert property (@(posedge mclk) disable iff (rst)
    $rose(prog_busy) |-> $past(stop_ev) && $past(pend_q)) else $error("prog without stop"); // (R6)

  // (R6) busy covers the whole count
  a_busy_count: assert property (@(posedge mclk) disable iff (rst)
    (pcnt_q != 16'h0000) |-> prog_busy) else $error("count without busy"); // (R6)

  // (R9) address ignored while busy
  a_busy_no_ack: assert property (@(posedge mclk) disable iff (rst)
    (clk_en && scl_fall && st_q == qpd_pkg::QPD_ST_ADDR && cnt_q == 4'h8 && prog_busy
     && !start_ev && !stop_ev && !ack_q) |=> !sda_oe) else $error("ack while busy"); // (R9)

  // (R5) direction bits unanswered
  a_step_no_ack: assert property (@(posedge mclk) disable iff (rst)
    (st_q == qpd_pkg::QPD_ST_STEP && !ack_q) |-> !sda_oe) else $error("ack in step"); // (R5)

  // (R5) line released between frames
  a_idle_no_ack: assert property (@(posedge mclk) disable iff (rst)
    (st_q == qpd_pkg::QPD_ST_IDLE) |-> !sda_oe) else $error("ack while idle"); // (R5)

  // (R7) step toward high terminal
  a_step_up: assert property (@(posedge mclk) disable iff (rst)
    (clk_en && st_q == qpd_pkg::QPD_ST_STEP && scl_fall && !ack_q && sh_q[0] && !start_ev
     && !stop_ev && wiper_position_register[pot_q*6 +: 6] != qpd_pkg::QPD_WIPER_MAX)
    |=> wiper_position_register[pot_q*6 +: 6] ==
        $past(wiper_position_register[pot_q*6 +: 6]) + 6'h01) else $error("no step up"); // (R7)

  // (R7) step toward low terminal
  a_step_down: assert property (@(posedge mclk) disable iff (rst)
    (clk_en && st_q == qpd_pkg::QPD_ST_STEP && scl_fall && !ack_q && !sh_q[0] && !start_ev
     && !stop_ev && wiper_position_register[pot_q*6 +: 6] != qpd_pkg::QPD_WIPER_RST)
    |=> wiper_position_register[pot_q*6 +: 6] ==
        $past(wiper_position_register[pot_q*6 +: 6]) - 6'h01) else $error("no step down"); // (R7)

  // (R3) slots change only at instruction decode
  a_slot_hold: assert property (@(posedge mclk) disable iff (rst)
    $changed(stored_setting_register) |->
      $past(st_q == qpd_pkg::QPD_ST_INST && scl_fall && cnt_q == 4'h8))
    else $error("slot changed outside decode"); // (R3)

  // (R4) wipers change only at decode or a step pulse
  a_wiper_hold: assert property (@(posedge mclk) disable iff (rst)
    $changed(wiper_position_register) |->
      $past(scl_fall && ((st_q == qpd_pkg::QPD_ST_INST && cnt_q == 4'h8)
                         || st_q == qpd_pkg::QPD_ST_STEP)))
    else $error("wiper changed outside decode"); // (R4)

  // (R2) pending save only from a saving instruction
  a_pend_save: assert property (@(posedge mclk) disable iff (rst)
    $rose(pend_q) |-> $past(sh_q[7:4]) == qpd_pkg::QPD_OP_GSAVE
                   || $past(sh_q[7:4]) == qpd_pkg::QPD_OP_SAVE) else $error("bad pend"); // (R2)
endmodule // qpd_decoder

// File: testbench/qpd_master.sv
// i2c master model sending instruction frames, 160 ns per bit
module qpd_master (
  // clock and sensed line
  input  wire logic mclk,
  input  wire logic sda_line,
  // bus lines
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic start_f();
    sda = 1'b0;
    w(4);
    scl = 1'b0;
    w(4);
  endtask
  // data changes only while scl is low
  task automatic bit_f(input logic b, output logic s);
    w(1);
    sda = b;
    w(3);
    scl = 1'b1;
    w(2);
    s = sda_line;
    w(2);
    scl = 1'b0;
  endtask
  // msb first, ninth bit released for ack
  task automatic byte_f(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_f(v[i], s);
    bit_f(1'b1, ack);
  endtask
  task automatic stop_f();
    w(1);
    sda = 1'b0;
    w(3);
    scl = 1'b1;
    w(3);
    sda = 1'b1;
    w(4);
  endtask
endmodule // qpd_master

// File: testbench/qpd_decoder_test.sv
// self-checking bench for the quad pot instruction decoder
module qpd_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst, scl, sda, sda_out, sda_oe, busy, a;
  logic [23:0] wpr;
  logic [95:0] ssr;
  int          errors = 0;
  int          checks = 0;
  // open drain line with pull-up
  wire sda_line = sda & ~sda_oe;
  qpd_master m_u (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda(sda));
  // long programming time so a frame fits inside it
  qpd_decoder #(.PROG_CYC(400)) dut_u (.mclk(mclk), .rst(rst), .clk_en(1'b1),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap(4'ha), .wiper_position_register(wpr),
    .stored_setting_register(ssr), .prog_busy(busy));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // frame up to the stop; ok low means the address must go unanswered
  task automatic frame(input logic [7:0] ins, input logic ok, input int n,
                       input logic [7:0] dirs);
    m_u.start_f();
    m_u.byte_f(8'h5a, a);
    check(a, !ok);
    if (ok) begin
      m_u.byte_f(ins, a);
      check(a, 1'b0);
      for (int i = n - 1; i >= 0; i--) begin
        m_u.bit_f(dirs[i], a);
        check(a, dirs[i]);
      end
    end
  endtask
  // programming must end before the store is trusted
  task automatic idle_wait();
    for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge mclk);
    check(busy, 1'b0);
  endtask
  initial begin
    rst = 1'b1;
    repeat (16) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    repeat (4) @(negedge mclk);
    frame(8'h21, 1'b1, 4, 8'h0e);
    m_u.stop_f();
    check(wpr, 24'h000080);
    check(sda_out, 1'b0);
    frame(8'he9, 1'b1, 0, 8'h00);
    check(busy, 1'b0);
    m_u.stop_f();
    check(busy, 1'b1);
    frame(8'h00, 1'b0, 0, 8'h00);
    m_u.stop_f();
    idle_wait();
    check(ssr, 96'h2 << 36);
    frame(8'h21, 1'b1, 2, 8'h00);
    m_u.stop_f();
    check(wpr, 24'h0);
    frame(8'hd9, 1'b1, 0, 8'h00);
    m_u.stop_f();
    check({busy, wpr}, 25'h0000080);
    frame(8'h23, 1'b1, 1, 8'h01);
    m_u.stop_f();
    frame(8'h8c, 1'b1, 0, 8'h00);
    m_u.stop_f();
    idle_wait();
    check(ssr, (96'h2 << 36) | (96'h2 << 42) | (96'h1 << 90));
    frame(8'h10, 1'b1, 0, 8'h00);
    m_u.stop_f();
    check(wpr, 24'h0);
    frame(8'h1c, 1'b1, 0, 8'h00);
    m_u.stop_f();
    check(wpr, 24'h040080);
    end_sim();
  end
  // hang guard, well past the expected run length
  initial begin
    #200000;
    errors++;
    end_sim();
  end
endmodule // qpd_decoder_test
